// *** logic/exec_pkg.sv ***
// Constants, opcodes and carriers shared by the instruction execution unit.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package exec_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_FLAGS = 8'h08;
   localparam logic [7:0] OFF_WREG = 8'h0C;
   localparam logic [7:0] OFF_PC = 8'h10;
   localparam logic [7:0] OFF_STACK = 8'h14;
   localparam logic [7:0] OFF_CTRL = 8'h18;
   localparam logic [7:0] OFF_WDOG = 8'h1C;
   localparam logic [7:0] OFF_DMEM = 8'h40;

   // Field positions of the control register.
   localparam int CTRL_IRQ_BIT = 0;
   localparam int CTRL_WAKE_BIT = 1;

   // Opcodes written into the instruction register.
   localparam logic [5:0] OP_IDLE_INSTRUCTION = 6'h00;
   localparam logic [5:0] OP_DECIMAL_ADJUST = 6'h01;
   localparam logic [5:0] OP_PLUS_ONE_MEM = 6'h02;
   localparam logic [5:0] OP_PLUS_ONE_TO_WREG = 6'h03;
   localparam logic [5:0] OP_MINUS_ONE_MEM = 6'h04;
   localparam logic [5:0] OP_MINUS_ONE_TO_WREG = 6'h05;
   localparam logic [5:0] OP_POWER_DOWN = 6'h06;
   localparam logic [5:0] OP_JUMP_ABSOLUTE = 6'h07;
   localparam logic [5:0] OP_COPY_MEM_TO_WREG = 6'h08;
   localparam logic [5:0] OP_COPY_IMM_TO_WREG = 6'h09;
   localparam logic [5:0] OP_COPY_WREG_TO_MEM = 6'h0A;
   localparam logic [5:0] OP_UNION_MEM = 6'h0B;
   localparam logic [5:0] OP_UNION_IMM = 6'h0C;
   localparam logic [5:0] OP_BITWISE_UNION_TO_MEM = 6'h0D;
   localparam logic [5:0] OP_SUBROUTINE_EXIT = 6'h0E;
   localparam logic [5:0] OP_SUBROUTINE_EXIT_IMM = 6'h0F;
   localparam logic [5:0] OP_INTERRUPT_EXIT = 6'h10;
   localparam logic [5:0] OP_ROTATE_LEFT = 6'h11;
   localparam logic [5:0] OP_ROTATE_LEFT_TO_WREG = 6'h12;
   localparam logic [5:0] OP_ROTATE_LEFT_CARRY = 6'h13;
   localparam logic [5:0] OP_ROTATE_LEFT_CARRY_TO_WREG = 6'h14;
   localparam logic [5:0] OP_ROTATE_RIGHT = 6'h15;
   localparam logic [5:0] OP_ROTATE_RIGHT_TO_WREG = 6'h16;
   localparam logic [5:0] OP_ROTATE_RIGHT_CARRY = 6'h17;
   localparam logic [5:0] OP_ROTATE_RIGHT_CARRY_TO_WREG = 6'h18;
   localparam logic [5:0] OP_SUBTRACT_BORROW = 6'h19;
   localparam logic [5:0] OP_SUBTRACT_BORROW_TO_MEM = 6'h1A;
   localparam logic [5:0] OP_MINUS_ONE_SKIP_ZERO = 6'h1B;
   localparam logic [5:0] OP_MINUS_ONE_SKIP_ZERO_WREG = 6'h1C;

   // Decimal adjust constants and nibble limit.
   localparam logic [7:0] ADJ_LOW = 8'h06;
   localparam logic [7:0] ADJ_HIGH = 8'h60;
   localparam logic [3:0] BCD_MAX = 4'h9;

   // Reset values and the interrupt vector.
   localparam logic [7:0] WREG_RESET = 8'h00;
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam logic [11:0] IRQ_VECTOR = 12'h004;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY} exec_state_e;

   // Instruction register layout: opcode, memory index or immediate, target.
   typedef struct packed {
      logic [11:0] target;
      logic [7:0] operand;
      logic [5:0] op;
   } instr_s;

   typedef struct packed {
      logic master_interrupt_enable;
      logic ov;
      logic z;
      logic ac;
      logic c;
   } flags_s;

endpackage

// *** logic/instr_exec.sv ***
// Execution unit for a subset of an 8-bit microcontroller instruction set.
// Assumes an APB master on pclk; software writes one instruction at a time.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

module instr_exec #(
   parameter int DMEM_AW = 4,
   parameter int STACK_DEPTH = 4,
   parameter int WDOG_W = 16,
   parameter int PRESC_W = 8
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   exec_pkg::exec_state_e st_q;
   exec_pkg::instr_s instr_q;
   exec_pkg::flags_s flags_q;
   exec_pkg::flags_s flags_d;
   logic [7:0] wreg_q;
   logic [11:0] pc_q;
   logic [11:0] pc_d;
   logic [7:0] dmem_q [2**DMEM_AW];
   logic [11:0] stack_q [STACK_DEPTH];
   logic [SP_W-1:0] sp_q;
   logic halted_q;
   logic pdf_q;
   logic tmo_q;
   logic irq_pend_q;
   logic [WDOG_W-1:0] wdog_q;
   logic [PRESC_W-1:0] presc_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // Bus decode.
   logic access;
   logic fire;
   logic wr_fire;
   logic in_dmem;
   logic mapped;
   logic [DMEM_AW-1:0] bus_idx;

   // Execution datapath.
   logic [DMEM_AW-1:0] m_idx;
   logic [7:0] m_val;
   logic [7:0] res;
   logic wr_mem;
   logic wr_acc;
   logic two_cycle;
   logic pop;
   logic [11:0] stack_top;
   logic [8:0] diff;
   logic [4:0] diff_lo;
   logic [8:0] bcd_sum;
   logic adj_lo;
   logic adj_hi;
   logic launch;
   logic exec;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // One wait state lets the read data and the answer come from flops.
   assign access = psel && penable;
   assign fire = access && pready_q;
   assign wr_fire = fire && pwrite;
   assign in_dmem = (paddr >= exec_pkg::OFF_DMEM) &&
      (paddr < exec_pkg::OFF_DMEM + 8'((2**DMEM_AW) * 4));
   assign bus_idx = DMEM_AW'((paddr - exec_pkg::OFF_DMEM) >> 2);
   assign mapped = (paddr[1:0] == 2'b00) && (in_dmem ||
      paddr <= exec_pkg::OFF_WDOG);
   assign launch = wr_fire && paddr == exec_pkg::OFF_INSTR &&
      st_q == exec_pkg::ST_IDLE && !halted_q;
   assign exec = st_q == exec_pkg::ST_EXEC;

   assign m_idx = instr_q.operand[DMEM_AW-1:0];
   assign m_val = dmem_q[m_idx];
   assign stack_top = stack_q[SP_W'(sp_q - 1'b1)];
   // Borrow in is the inverted carry; bit 8 set means the result went below 0.
   assign diff = {1'b0, wreg_q} - {1'b0, m_val} - {8'h00, ~flags_q.c};
   assign diff_lo = {1'b0, wreg_q[3:0]} - {1'b0, m_val[3:0]} -
      {4'h0, ~flags_q.c};
   assign adj_lo = wreg_q[3:0] > exec_pkg::BCD_MAX || flags_q.ac;
   assign adj_hi = wreg_q[7:4] > exec_pkg::BCD_MAX || flags_q.c;
   assign bcd_sum = {1'b0, wreg_q} +
      {1'b0, adj_lo ? exec_pkg::ADJ_LOW : 8'h00} +
      {1'b0, adj_hi ? exec_pkg::ADJ_HIGH : 8'h00};

   always_comb begin
      res = m_val;
      wr_mem = 1'b0;
      wr_acc = 1'b0;
      two_cycle = 1'b0;
      pop = 1'b0;
      flags_d = flags_q;
      pc_d = 12'(pc_q + 1'b1);
      case (instr_q.op)
         exec_pkg::OP_DECIMAL_ADJUST: begin
            res = bcd_sum[7:0];
            wr_mem = 1'b1;
            flags_d.c = bcd_sum[8] | flags_q.c;
         end
         exec_pkg::OP_PLUS_ONE_MEM, exec_pkg::OP_PLUS_ONE_TO_WREG: begin
            res = 8'(m_val + 1'b1);
            wr_mem = instr_q.op == exec_pkg::OP_PLUS_ONE_MEM;
            wr_acc = !wr_mem;
            flags_d.z = res == 8'h00;
         end
         exec_pkg::OP_MINUS_ONE_MEM, exec_pkg::OP_MINUS_ONE_TO_WREG: begin
            res = 8'(m_val - 1'b1);
            wr_mem = instr_q.op == exec_pkg::OP_MINUS_ONE_MEM;
            wr_acc = !wr_mem;
            flags_d.z = res == 8'h00;
         end
         exec_pkg::OP_JUMP_ABSOLUTE: begin
            pc_d = instr_q.target;
            two_cycle = 1'b1;
         end
         exec_pkg::OP_COPY_MEM_TO_WREG: wr_acc = 1'b1;
         exec_pkg::OP_COPY_IMM_TO_WREG: begin
            res = instr_q.operand;
            wr_acc = 1'b1;
         end
         exec_pkg::OP_COPY_WREG_TO_MEM: begin
            res = wreg_q;
            wr_mem = 1'b1;
         end
         exec_pkg::OP_UNION_MEM, exec_pkg::OP_UNION_IMM,
         exec_pkg::OP_BITWISE_UNION_TO_MEM: begin
            res = wreg_q | (instr_q.op == exec_pkg::OP_UNION_IMM ?
               instr_q.operand : m_val);
            wr_mem = instr_q.op == exec_pkg::OP_BITWISE_UNION_TO_MEM;
            wr_acc = !wr_mem;
            flags_d.z = res == 8'h00;
         end
         exec_pkg::OP_SUBROUTINE_EXIT, exec_pkg::OP_SUBROUTINE_EXIT_IMM: begin
            pc_d = stack_top;
            pop = 1'b1;
            two_cycle = 1'b1;
            res = instr_q.operand;
            wr_acc = instr_q.op == exec_pkg::OP_SUBROUTINE_EXIT_IMM;
         end
         exec_pkg::OP_INTERRUPT_EXIT: begin
            two_cycle = 1'b1;
            // The return address stays stacked so the handler returns to it.
            if (irq_pend_q) begin
               pc_d = exec_pkg::IRQ_VECTOR;
               flags_d.master_interrupt_enable = 1'b0;
            end else begin
               pc_d = stack_top;
               pop = 1'b1;
               flags_d.master_interrupt_enable = 1'b1;
            end
         end
         exec_pkg::OP_ROTATE_LEFT, exec_pkg::OP_ROTATE_LEFT_TO_WREG: begin
            res = {m_val[6:0], m_val[7]};
            wr_mem = instr_q.op == exec_pkg::OP_ROTATE_LEFT;
            wr_acc = !wr_mem;
         end
         exec_pkg::OP_ROTATE_LEFT_CARRY,
         exec_pkg::OP_ROTATE_LEFT_CARRY_TO_WREG: begin
            res = {m_val[6:0], flags_q.c};
            flags_d.c = m_val[7];
            wr_mem = instr_q.op == exec_pkg::OP_ROTATE_LEFT_CARRY;
            wr_acc = !wr_mem;
         end
         exec_pkg::OP_ROTATE_RIGHT, exec_pkg::OP_ROTATE_RIGHT_TO_WREG: begin
            res = {m_val[0], m_val[7:1]};
            wr_mem = instr_q.op == exec_pkg::OP_ROTATE_RIGHT;
            wr_acc = !wr_mem;
         end
         exec_pkg::OP_ROTATE_RIGHT_CARRY,
         exec_pkg::OP_ROTATE_RIGHT_CARRY_TO_WREG: begin
            res = {flags_q.c, m_val[7:1]};
            flags_d.c = m_val[0];
            wr_mem = instr_q.op == exec_pkg::OP_ROTATE_RIGHT_CARRY;
            wr_acc = !wr_mem;
         end
         exec_pkg::OP_SUBTRACT_BORROW, exec_pkg::OP_SUBTRACT_BORROW_TO_MEM: begin
            res = diff[7:0];
            wr_mem = instr_q.op == exec_pkg::OP_SUBTRACT_BORROW_TO_MEM;
            wr_acc = !wr_mem;
            flags_d.z = res == 8'h00;
            flags_d.ac = ~diff_lo[4];
            flags_d.ov = (wreg_q[7] ^ m_val[7]) & (wreg_q[7] ^ res[7]);
            flags_d.c = ~diff[8];
         end
         exec_pkg::OP_MINUS_ONE_SKIP_ZERO,
         exec_pkg::OP_MINUS_ONE_SKIP_ZERO_WREG: begin
            res = 8'(m_val - 1'b1);
            wr_mem = instr_q.op == exec_pkg::OP_MINUS_ONE_SKIP_ZERO;
            wr_acc = !wr_mem;
            if (res == 8'h00) begin
               pc_d = 12'(pc_q + 2'd2);
               two_cycle = 1'b1;
            end
         end
         default: ;
      endcase
   end

   // Sequencer: the dummy cycle follows every two-cycle instruction.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= exec_pkg::ST_IDLE;
         instr_q <= '0;
      end else begin
         case (st_q)
            exec_pkg::ST_IDLE: begin
               if (launch) begin
                  instr_q <= exec_pkg::instr_s'(pwdata[25:0]);
                  st_q <= exec_pkg::ST_EXEC;
               end
            end
            exec_pkg::ST_EXEC: begin
               st_q <= two_cycle ? exec_pkg::ST_DUMMY : exec_pkg::ST_IDLE;
            end
            default: st_q <= exec_pkg::ST_IDLE;
         endcase
      end
   end

   // Working register, flags and program counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wreg_q <= exec_pkg::WREG_RESET;
         flags_q <= '0;
         pc_q <= exec_pkg::PC_RESET;
      end else if (exec) begin
         if (wr_acc) begin
            wreg_q <= res;
         end
         flags_q <= flags_d;
         // A power-down instruction leaves the counter at itself.
         if (instr_q.op != exec_pkg::OP_POWER_DOWN) begin
            pc_q <= pc_d;
         end
      end else if (wr_fire && st_q == exec_pkg::ST_IDLE) begin
         if (paddr == exec_pkg::OFF_WREG) begin
            wreg_q <= pwdata[7:0];
         end
         if (paddr == exec_pkg::OFF_FLAGS) begin
            flags_q <= exec_pkg::flags_s'(pwdata[4:0]);
         end
      end
   end

   // Data memory; software writes are refused while an instruction runs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2**DMEM_AW; i++) begin
            dmem_q[i] <= 8'h00;
         end
      end else if (exec && wr_mem) begin
         dmem_q[m_idx] <= res;
      end else if (wr_fire && in_dmem && st_q == exec_pkg::ST_IDLE) begin
         dmem_q[bus_idx] <= pwdata[7:0];
      end
   end

   // Return stack: software pushes stand in for calls.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_q <= '0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_q[i] <= exec_pkg::PC_RESET;
         end
      end else if (exec && pop) begin
         sp_q <= SP_W'(sp_q - 1'b1);
      end else if (wr_fire && paddr == exec_pkg::OFF_STACK &&
         st_q == exec_pkg::ST_IDLE) begin
         stack_q[sp_q] <= pwdata[11:0];
         sp_q <= SP_W'(sp_q + 1'b1);
      end
   end

   // Pending interrupt: a software set in the servicing cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pend_q <= 1'b0;
      end else if (wr_fire && paddr == exec_pkg::OFF_CTRL &&
         pwdata[exec_pkg::CTRL_IRQ_BIT]) begin
         irq_pend_q <= 1'b1;
      end else if (exec && instr_q.op == exec_pkg::OP_INTERRUPT_EXIT) begin
         irq_pend_q <= 1'b0;
      end
   end

   // Power down; only the wake bit resumes execution.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted_q <= 1'b0;
         pdf_q <= 1'b0;
      end else if (exec && instr_q.op == exec_pkg::OP_POWER_DOWN) begin
         halted_q <= 1'b1;
         pdf_q <= 1'b1;
      end else if (wr_fire && paddr == exec_pkg::OFF_CTRL &&
         pwdata[exec_pkg::CTRL_WAKE_BIT]) begin
         halted_q <= 1'b0;
      end
   end

   // Watchdog stands still while halted, as its clock would be gated.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_q <= '0;
         wdog_q <= '0;
         tmo_q <= 1'b0;
      end else if (exec && instr_q.op == exec_pkg::OP_POWER_DOWN) begin
         presc_q <= '0;
         wdog_q <= '0;
         tmo_q <= 1'b0;
      end else if (!halted_q) begin
         presc_q <= PRESC_W'(presc_q + 1'b1);
         if (&presc_q) begin
            wdog_q <= WDOG_W'(wdog_q + 1'b1);
            if (&wdog_q) begin
               tmo_q <= 1'b1;
            end
         end
      end
   end

   // APB answer and read data.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= access && !pready_q;
         pslverr_q <= access && !pready_q && !mapped;
         prdata_q <= '0;
         if (access && !pready_q && !pwrite) begin
            if (in_dmem) begin
               prdata_q <= {24'h000000, dmem_q[bus_idx]};
            end else if (paddr == exec_pkg::OFF_INSTR) begin
               prdata_q <= {6'h00, instr_q};
            end else if (paddr == exec_pkg::OFF_STATUS) begin
               prdata_q <= {27'h0, irq_pend_q, tmo_q, pdf_q, halted_q,
                  st_q != exec_pkg::ST_IDLE};
            end else if (paddr == exec_pkg::OFF_FLAGS) begin
               prdata_q <= {27'h0, flags_q};
            end else if (paddr == exec_pkg::OFF_WREG) begin
               prdata_q <= {24'h000000, wreg_q};
            end else if (paddr == exec_pkg::OFF_PC) begin
               prdata_q <= {20'h00000, pc_q};
            end else if (paddr == exec_pkg::OFF_STACK) begin
               prdata_q <= {20'h00000, stack_top};
            end else if (paddr == exec_pkg::OFF_WDOG) begin
               prdata_q <= 32'(wdog_q);
            end
         end
      end
   end

   sequence s_exec_op(logic [5:0] op);
      exec && instr_q.op == op;
   endsequence

   sequence s_two_cycle_tail;
      st_q == exec_pkg::ST_DUMMY ##1 st_q == exec_pkg::ST_IDLE;
   endsequence

   property p_jump_two_cycles;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_JUMP_ABSOLUTE) |=>
         s_two_cycle_tail and pc_q == $past(instr_q.target);
   endproperty
   a_jump_two_cycles: assert property (p_jump_two_cycles)
      else $error("jump did not load target in two cycles");

   property p_jump_flags;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_JUMP_ABSOLUTE) |=> $stable(flags_q);
   endproperty
   a_jump_flags: assert property (p_jump_flags)
      else $error("jump changed a flag");

   property p_idle_advance;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_IDLE_INSTRUCTION) |=>
         pc_q == 12'($past(pc_q) + 1'b1) && $stable(flags_q) &&
         $stable(wreg_q) && st_q == exec_pkg::ST_IDLE;
   endproperty
   a_idle_advance: assert property (p_idle_advance)
      else $error("idle instruction changed state");

   property p_power_down;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_POWER_DOWN) |=>
         halted_q && pdf_q && !tmo_q && wdog_q == '0 && presc_q == '0;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("power down did not clear watchdog or set flag");

   property p_halt_holds;
      @(posedge pclk) disable iff (!presetn)
      halted_q && !launch |=> $stable(wreg_q) && $stable(pc_q) &&
         $stable(wdog_q);
   endproperty
   a_halt_holds: assert property (p_halt_holds)
      else $error("state changed while powered down");

   property p_sub_carry;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_SUBTRACT_BORROW) |=>
         flags_q.c == !$past(diff[8]) && wreg_q == $past(diff[7:0]);
   endproperty
   a_sub_carry: assert property (p_sub_carry)
      else $error("subtract carry or result wrong");

   property p_skip_zero;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_MINUS_ONE_SKIP_ZERO) ##0 m_val == 8'h01 |=>
         pc_q == 12'($past(pc_q) + 2'd2) ##0 s_two_cycle_tail;
   endproperty
   a_skip_zero: assert property (p_skip_zero)
      else $error("decrement to zero did not skip");

   property p_interrupt_exit;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_INTERRUPT_EXIT) ##0 !irq_pend_q |=>
         flags_q.master_interrupt_enable && pc_q == $past(stack_top);
   endproperty
   a_interrupt_exit: assert property (p_interrupt_exit)
      else $error("interrupt exit did not restore and enable");

   property p_pending_first;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_INTERRUPT_EXIT) ##0 irq_pend_q |=>
         pc_q == exec_pkg::IRQ_VECTOR && sp_q == $past(sp_q);
   endproperty
   a_pending_first: assert property (p_pending_first)
      else $error("pending interrupt not serviced first");

   property p_rotate_left;
      @(posedge pclk) disable iff (!presetn)
      s_exec_op(exec_pkg::OP_ROTATE_LEFT_TO_WREG) |=>
         wreg_q == {$past(m_val[6:0]), $past(m_val[7])} && $stable(flags_q);
   endproperty
   a_rotate_left: assert property (p_rotate_left)
      else $error("left rotate result wrong");

endmodule

// *** testbench/apb_host.sv ***
// APB master standing in for the software that drives the unit.
// Assumes the bench calls xfer only right after a rising pclk edge.
`timescale 1ns/1ps
module apb_host (
   // Clock and slave answer.
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // Request.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // The request is held until pready is seen; the bench timeout ends a hang.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// *** testbench/mcu_instruction_execution_tb_top.sv ***
// Random instruction bench with an integer reference model of the unit.
// Assumes the register map and timing of the execution unit hand-over.
`timescale 1ns/1ps
module mcu_instruction_execution_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [5:0] op;
   int n_errors = 0, compares = 0;
   int w, m, f, c, ac, z, ov, e, pc, npc, idx, opr, tgt, stk, r, i;
   always #12.5 pclk = ~pclk;
   instr_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   apb_host host_u (.pclk(pclk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   function automatic int rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return int'(seed & 32'h7FFFFFFF);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rg(input logic [7:0] a);
      host_u.xfer(1'b0, a, 32'h0, rd, er);
   endtask
   task automatic wg(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, rd, er);
   endtask
   // Busy is polled, since two-cycle operations finish one edge later.
   task automatic run(input logic [5:0] o, input int x);
      int k;
      wg(exec_pkg::OFF_INSTR, 32'((tgt << 14) | (x << 6) | o));
      for (k = 0; k < 10; k++) begin
         rg(exec_pkg::OFF_STATUS);
         if (rd[0] === 1'b0) break;
      end
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #(25 * 40000);
      n_errors++;
      wrap_up();
   end
   initial begin
      seed = 32'hE3800FC3;
      tgt = 0;
      pc = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rg(exec_pkg::OFF_FLAGS);
      chk(rd, 32'h0);
      rg(8'h20);
      chk({rd[30:0], er}, 32'h1);
      for (i = 0; i < 250; i++) begin
         op = 6'(rnd() % 29);
         if (op == exec_pkg::OP_POWER_DOWN) op = exec_pkg::OP_IDLE_INSTRUCTION;
         w = rnd() & 255;
         m = (op > 6'h1A && rnd() % 2 == 1) ? 1 : rnd() & 255;
         f = rnd() & 31;
         idx = rnd() & 15;
         tgt = rnd() & 4095;
         stk = rnd() & 4095;
         opr = (op == 6'h09 || op == 6'h0C || op == 6'h0F) ? rnd() & 255 : idx;
         wg(exec_pkg::OFF_WREG, w);
         wg(exec_pkg::OFF_FLAGS, f);
         wg(exec_pkg::OFF_DMEM + 8'(idx * 4), m);
         wg(exec_pkg::OFF_STACK, stk);
         run(op, opr);
         e = f[4];
         ov = f[3];
         z = f[2];
         ac = f[1];
         c = f[0];
         npc = (pc + 1) & 4095;
         case (op)
            6'h01: begin
               r = w + ((w % 16 > 9 || ac) ? 6 : 0) + ((w / 16 > 9 || c) ? 96 : 0);
               m = r & 255;
               c = c | (r > 255);
            end
            6'h02: m = (m + 1) & 255;
            6'h03: w = (m + 1) & 255;
            6'h04, 6'h1B: m = (m - 1) & 255;
            6'h05, 6'h1C: w = (m - 1) & 255;
            6'h07: npc = tgt;
            6'h08: w = m;
            6'h09: w = opr;
            6'h0A: m = w;
            6'h0B, 6'h0C: w = w | ((op == 6'h0C) ? opr : m);
            6'h0D: m = w | m;
            6'h0E, 6'h0F, 6'h10: npc = stk;
            6'h11, 6'h12: r = ((m << 1) | (m >> 7)) & 255;
            6'h13, 6'h14: r = ((m << 1) | c) & 255;
            6'h15, 6'h16: r = (m >> 1) | ((m & 1) << 7);
            6'h17, 6'h18: r = (m >> 1) | (c << 7);
            6'h19, 6'h1A: begin
               r = w - m - (1 - c);
               ac = ((w & 15) - (m & 15) - (1 - c)) >= 0;
               ov = ((w ^ m) & (w ^ r) & 128) != 0;
               c = r >= 0;
               z = (r & 255) == 0;
               if (op == 6'h19) w = r & 255;
               else m = r & 255;
            end
            default: ;
         endcase
         if (op == 6'h0F) w = opr;
         if (op == 6'h10) e = 1;
         if (op == 6'h13 || op == 6'h14) c = m >> 7;
         if (op == 6'h17 || op == 6'h18) c = m & 1;
         if (op inside {6'h12, 6'h14, 6'h16, 6'h18}) w = r;
         if (op inside {6'h11, 6'h13, 6'h15, 6'h17}) m = r;
         if (op inside {6'h02, 6'h04, 6'h0D}) z = m == 0;
         if (op inside {6'h03, 6'h05, 6'h0B, 6'h0C}) z = w == 0;
         if ((op == 6'h1B && m == 0) || (op == 6'h1C && w == 0))
            npc = (pc + 2) & 4095;
         rg(exec_pkg::OFF_WREG);
         chk(rd, w);
         rg(exec_pkg::OFF_DMEM + 8'(idx * 4));
         chk(rd, m);
         rg(exec_pkg::OFF_FLAGS);
         r = e * 16 + ov * 8 + z * 4 + ac * 2 + c;
         chk(rd, r);
         rg(exec_pkg::OFF_PC);
         chk(rd, npc);
         pc = npc;
      end
      wg(exec_pkg::OFF_STACK, 32'h123);
      wg(exec_pkg::OFF_CTRL, 32'h1);
      run(exec_pkg::OP_INTERRUPT_EXIT, 0);
      rg(exec_pkg::OFF_PC);
      chk(rd, 32'h004);
      run(exec_pkg::OP_POWER_DOWN, 0);
      rg(exec_pkg::OFF_STATUS);
      chk(rd[4:1], 4'b0011);
      rg(exec_pkg::OFF_WDOG);
      chk(rd, 32'h0);
      run(exec_pkg::OP_IDLE_INSTRUCTION, 0);
      rg(exec_pkg::OFF_PC);
      chk(rd, 32'h004);
      wg(exec_pkg::OFF_CTRL, 32'h2);
      run(exec_pkg::OP_IDLE_INSTRUCTION, 0);
      rg(exec_pkg::OFF_PC);
      chk(rd, 32'h005);
      wrap_up();
   end
endmodule
